// ---- shared/ccs_pkg.sv ----
// Package with register map, field positions, reset values and bus carriers for the timer.
package ccs_pkg;
   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_IRQ_EN = 8'h04;
   localparam logic [7:0] OFS_CTRL = 8'h08;
   localparam logic [7:0] OFS_COUNT = 8'h0C;
   localparam logic [7:0] OFS_CMP_A = 8'h10;
   localparam logic [7:0] OFS_CMP_B = 8'h14;
   localparam logic [7:0] OFS_CAP_A = 8'h18;
   localparam logic [7:0] OFS_CAP_B = 8'h1C;
   localparam logic [7:0] OFS_CAP_C = 8'h20;
   localparam logic [7:0] OFS_CAP_D = 8'h24;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int BIT_CAP_A_FLAG = 7;
   localparam int BIT_CAP_B_FLAG = 6;
   localparam int BIT_CAP_C_FLAG = 5;
   localparam int BIT_CAP_D_FLAG = 4;
   localparam int BIT_CMP_A_FLAG = 3;
   localparam int BIT_CMP_B_FLAG = 2;
   localparam int BIT_OVF_FLAG = 1;
   localparam int BIT_CLR_MATCH = 0;
   localparam int BIT_OVF_IRQ_EN = 1;
   localparam int BIT_CAP_A_SRC = 0;
   localparam int BIT_BUF_A = 3;
   localparam int BIT_BUF_B = 2;
   // ----------------------------------------
   // Reset values and encodings
   // ----------------------------------------
   localparam logic [7:0] RST_REG8 = 8'h00;
   localparam logic [15:0] RST_COUNT = 16'h0000;
   localparam logic [15:0] RST_CMP = 16'hFFFF;
   localparam logic [15:0] RST_CAP = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;
   localparam logic [1:0] CKS_DIV4 = 2'h0;
   localparam logic [1:0] CKS_DIV16 = 2'h1;
   localparam logic [1:0] CKS_DIV64 = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ----------------------------------------
   // Bus carriers
   // ----------------------------------------
   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } ccs_axi_req_t;
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } ccs_axi_rsp_t;
endpackage : ccs_pkg

// ---- src/ccs_edge_detect.sv ----
// Pin synchroniser with selectable edge detection.
`timescale 1ns/100ps
module ccs_edge_detect
   import ccs_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic pin_i,
   input wire logic rise_sel_i,
   output logic edge_o
);
   logic meta_q;
   logic sync_q;
   logic prev_q;

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= pin_i;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // Edge pulse is registered so capture sees a clean single cycle.
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         edge_o <= 1'b0;
      end else begin
         edge_o <= rise_sel_i ? (sync_q & ~prev_q) : (~sync_q & prev_q);
      end
   end
endmodule : ccs_edge_detect

// ---- src/ccs_prescaler.sv ----
// Clock-enable divider for the counter.
`timescale 1ns/100ps
module ccs_prescaler
   import ccs_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic hold_i,
   input wire logic [1:0] sel_i,
   input wire logic ext_tick_i,
   output logic tick_o
);
   logic [5:0] div_q;

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i || hold_i) begin
         div_q <= 6'h00;
      end else begin
         div_q <= div_q + 6'h01;
      end
   end

   always_comb begin
      case (sel_i)
         CKS_DIV4: tick_o = &div_q[1:0];
         CKS_DIV16: tick_o = &div_q[3:0];
         CKS_DIV64: tick_o = &div_q;
         default: tick_o = ext_tick_i;
      endcase
   end
endmodule : ccs_prescaler

// ---- src/ccs_timer.sv ----
// Free-running timer with captures, compares, status flags and AXI4-Lite registers.
`timescale 1ns/100ps
module ccs_timer
   import ccs_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic low_power_i,
   input wire ccs_axi_req_t axi_req_i,
   output ccs_axi_rsp_t axi_rsp_o,
   input wire logic cap_a_pin_i,
   input wire logic head_switch_signal_i,
   input wire logic cap_b_pin_i,
   input wire logic cap_c_pin_i,
   input wire logic cap_d_pin_i,
   input wire logic ext_count_pulse_i,
   output logic [7:1] irq_o
);
   // ----------------------------------------
   // Functions
   // ----------------------------------------
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] st);
      merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
   endfunction : merge16

   function automatic logic known_addr(input logic [7:0] a);
      known_addr = (a[1:0] == 2'h0) && (a <= OFS_CAP_D);
   endfunction : known_addr

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic init;
   logic [7:1] flag_q;
   logic [7:1] armed_q;
   logic clr_match_q;
   logic [7:0] irq_en_q;
   logic [7:0] ctrl_q;
   logic [15:0] count_q;
   logic [15:0] cmp_a_q;
   logic [15:0] cmp_b_q;
   logic [15:0] cap_a_q;
   logic [15:0] cap_b_q;
   logic [15:0] cap_c_q;
   logic [15:0] cap_d_q;
   logic aw_have_q;
   logic w_have_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic wr_go;
   logic rd_go;
   logic [7:1] set_v;
   logic [7:1] clr_v;
   logic [4:0] pin_v;
   logic [4:0] rise_v;
   logic [4:0] edge_v;
   logic tick;
   logic match_a;
   logic match_b;
   logic count_clr;
   logic [15:0] count_d;

   // Low-power modes act as a functional reset of all timer state except the edge detectors and the bus channels.
   assign init = !rst_b_i || low_power_i;

   // ----------------------------------------
   // Capture inputs
   // ----------------------------------------
   // Source mux sits before the synchroniser so both sources see two flops.
   assign pin_v = {ext_count_pulse_i, cap_d_pin_i, cap_c_pin_i, cap_b_pin_i,
                   irq_en_q[BIT_CAP_A_SRC] ? head_switch_signal_i : cap_a_pin_i};
   assign rise_v = {1'b1, ctrl_q[4], ctrl_q[5], ctrl_q[6], ctrl_q[7]};

   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_edge
         ccs_edge_detect u_edge (
            .core_clk_i(core_clk_i),
            .rst_b_i(rst_b_i),
            .pin_i(pin_v[gi]),
            .rise_sel_i(rise_v[gi]),
            .edge_o(edge_v[gi])
         );
      end
   endgenerate

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   ccs_prescaler u_presc (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .hold_i(low_power_i),
      .sel_i(ctrl_q[1:0]),
      .ext_tick_i(edge_v[4]),
      .tick_o(tick)
   );

   assign match_a = tick && (count_q == cmp_a_q);
   assign match_b = tick && (count_q == cmp_b_q);
   assign count_clr = match_a && clr_match_q;

   always_comb begin
      count_d = count_q;
      if (count_clr) begin
         count_d = RST_COUNT;
      end else if (tick) begin
         count_d = count_q + 16'h0001;
      end
   end

   // A software write to the counter takes priority over counting.
   always_ff @(posedge core_clk_i) begin
      if (init) begin
         count_q <= RST_COUNT;
      end else if (wr_go && awaddr_q == OFS_COUNT) begin
         count_q <= merge16(count_q, wdata_q, wstrb_q);
      end else begin
         count_q <= count_d;
      end
   end

   // ----------------------------------------
   // Capture registers
   // ----------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (init) begin
         cap_a_q <= RST_CAP;
         cap_b_q <= RST_CAP;
         cap_c_q <= RST_CAP;
         cap_d_q <= RST_CAP;
      end else begin
         if (edge_v[0]) begin
            cap_a_q <= count_q;
         end
         if (edge_v[1]) begin
            cap_b_q <= count_q;
         end
         if (ctrl_q[BIT_BUF_A]) begin
            if (edge_v[0]) begin
               cap_c_q <= cap_a_q;
            end
         end else if (edge_v[2]) begin
            cap_c_q <= count_q;
         end
         if (ctrl_q[BIT_BUF_B]) begin
            if (edge_v[1]) begin
               cap_d_q <= cap_b_q;
            end
         end else if (edge_v[3]) begin
            cap_d_q <= count_q;
         end
      end
   end

   // ----------------------------------------
   // Status flags
   // ----------------------------------------
   // C and D events set their flags whatever the buffer mode.
   assign set_v = {edge_v[0], edge_v[1], edge_v[2], edge_v[3], match_a, match_b,
                   tick && !count_clr && count_q == COUNT_MAX};

   // Only a written 0 on a flag that was armed by an earlier read clears it.
   assign clr_v = (wr_go && awaddr_q == OFS_STATUS && wstrb_q[0]) ?
                  (armed_q & ~wdata_q[7:1]) : 7'h00;

   always_ff @(posedge core_clk_i) begin
      if (init) begin
         flag_q <= RST_REG8[7:1];
      end else begin
         flag_q <= set_v | (flag_q & ~clr_v);
      end
   end

   // A read that returns 1 arms the bit; any status write disarms it.
   always_ff @(posedge core_clk_i) begin
      if (init) begin
         armed_q <= RST_REG8[7:1];
      end else if (wr_go && awaddr_q == OFS_STATUS) begin
         armed_q <= RST_REG8[7:1];
      end else if (rd_go && axi_req_i.araddr == OFS_STATUS) begin
         armed_q <= armed_q | flag_q;
      end
   end

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (init) begin
         clr_match_q <= RST_REG8[BIT_CLR_MATCH];
         irq_en_q <= RST_REG8;
         ctrl_q <= RST_REG8;
      end else if (wr_go && wstrb_q[0]) begin
         case (awaddr_q)
            OFS_STATUS: clr_match_q <= wdata_q[BIT_CLR_MATCH];
            OFS_IRQ_EN: irq_en_q <= wdata_q[7:0];
            OFS_CTRL: ctrl_q <= wdata_q[7:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (init) begin
         cmp_a_q <= RST_CMP;
         cmp_b_q <= RST_CMP;
      end else if (wr_go) begin
         if (awaddr_q == OFS_CMP_A) begin
            cmp_a_q <= merge16(cmp_a_q, wdata_q, wstrb_q);
         end
         if (awaddr_q == OFS_CMP_B) begin
            cmp_b_q <= merge16(cmp_b_q, wdata_q, wstrb_q);
         end
      end
   end

   // ----------------------------------------
   // Interrupt requests
   // ----------------------------------------
   // Levels from flops; they drop in the same cycle as the flag or enable flop clears.
   assign irq_o = flag_q & irq_en_q[7:1];

   // ----------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------
   assign wr_go = aw_have_q && w_have_q && !bvalid_q;

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         aw_have_q <= 1'b0;
         awaddr_q <= 8'h00;
      end else if (axi_req_i.awvalid && axi_rsp_o.awready) begin
         aw_have_q <= 1'b1;
         awaddr_q <= axi_req_i.awaddr;
      end else if (wr_go) begin
         aw_have_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         w_have_q <= 1'b0;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
      end else if (axi_req_i.wvalid && axi_rsp_o.wready) begin
         w_have_q <= 1'b1;
         wdata_q <= axi_req_i.wdata;
         wstrb_q <= axi_req_i.wstrb;
      end else if (wr_go) begin
         w_have_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q <= known_addr(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (axi_req_i.bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------
   assign rd_go = axi_req_i.arvalid && !rvalid_q;

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= RESP_OKAY;
      end else if (rd_go) begin
         rvalid_q <= 1'b1;
         rresp_q <= known_addr(axi_req_i.araddr) ? RESP_OKAY : RESP_SLVERR;
         case (axi_req_i.araddr)
            OFS_STATUS: rdata_q <= {24'h000000, flag_q, clr_match_q};
            OFS_IRQ_EN: rdata_q <= {24'h000000, irq_en_q};
            OFS_CTRL: rdata_q <= {24'h000000, ctrl_q};
            OFS_COUNT: rdata_q <= {16'h0000, count_q};
            OFS_CMP_A: rdata_q <= {16'h0000, cmp_a_q};
            OFS_CMP_B: rdata_q <= {16'h0000, cmp_b_q};
            OFS_CAP_A: rdata_q <= {16'h0000, cap_a_q};
            OFS_CAP_B: rdata_q <= {16'h0000, cap_b_q};
            OFS_CAP_C: rdata_q <= {16'h0000, cap_c_q};
            OFS_CAP_D: rdata_q <= {16'h0000, cap_d_q};
            default: rdata_q <= 32'h00000000;
         endcase
      end else if (axi_req_i.rready) begin
         rvalid_q <= 1'b0;
      end
   end

   always_comb begin
      axi_rsp_o.awready = !aw_have_q && !bvalid_q;
      axi_rsp_o.wready = !w_have_q && !bvalid_q;
      axi_rsp_o.bvalid = bvalid_q;
      axi_rsp_o.bresp = bresp_q;
      axi_rsp_o.arready = !rvalid_q;
      axi_rsp_o.rvalid = rvalid_q;
      axi_rsp_o.rdata = rdata_q;
      axi_rsp_o.rresp = rresp_q;
   end
endmodule : ccs_timer

// ---- testbench/ccs_timer_monitor.sv ----
// Checker of bus answers and request levels at the timer ports.
`timescale 1ns/100ps
module ccs_timer_monitor
   import ccs_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic low_power_i,
   input wire ccs_axi_req_t axi_req_i,
   input wire ccs_axi_rsp_t axi_rsp_o,
   input wire logic [7:1] irq_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence s_ar_take;
      axi_req_i.arvalid && axi_rsp_o.arready;
   endsequence
   sequence s_wr_take;
      axi_req_i.awvalid && axi_rsp_o.awready && axi_req_i.wvalid && axi_rsp_o.wready;
   endsequence
   sequence s_b_answer;
      !axi_rsp_o.bvalid ##1 axi_rsp_o.bvalid;
   endsequence
   a_lp_irq_clear: assert property (low_power_i |=> irq_o == 7'h00)
      else $error("request left in low power");
   // A request may only drop when a register write lands or low power clears it.
   a_irq_hold: assert property ($past(rst_b_i) && ($past(irq_o) & ~irq_o) != 7'h00
      |-> $rose(axi_rsp_o.bvalid) || $past(low_power_i)) else $error("request dropped");
   a_read_answer: assert property (s_ar_take |=> axi_rsp_o.rvalid)
      else $error("read not answered");
   a_read_done: assert property (axi_rsp_o.rvalid && axi_req_i.rready |=> !axi_rsp_o.rvalid)
      else $error("read answer held");
   a_write_answer: assert property (s_wr_take |=> s_b_answer)
      else $error("write not answered");
   a_write_done: assert property (axi_rsp_o.bvalid && axi_req_i.bready |=> !axi_rsp_o.bvalid)
      else $error("write answer held");
   a_ar_refused: assert property (axi_rsp_o.rvalid |-> !axi_rsp_o.arready)
      else $error("read taken while busy");
   a_aw_refused: assert property (axi_rsp_o.bvalid |-> !axi_rsp_o.awready && !axi_rsp_o.wready)
      else $error("write taken while busy");
endmodule : ccs_timer_monitor

bind ccs_timer ccs_timer_monitor mon_u (
   .core_clk_i(core_clk_i),
   .rst_b_i(rst_b_i),
   .low_power_i(low_power_i),
   .axi_req_i(axi_req_i),
   .axi_rsp_o(axi_rsp_o),
   .irq_o(irq_o)
);

// ---- testbench/ccs_pin_model.sv ----
// Model of the capture pins, head switch and external count pulse source.
`timescale 1ns/100ps
module ccs_pin_model
(
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic [5:0] tgl_i,
   output logic [5:0] lvl_o
);
   logic [5:0] lvl_q;
   // Each request flips one line; flips are spaced far beyond the minimum pulse width.
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         lvl_q <= 6'h00;
      end else begin
         lvl_q <= lvl_q ^ tgl_i;
      end
   end
   assign lvl_o = lvl_q;
endmodule : ccs_pin_model

// ---- testbench/tb_capture_compare_status_flags.sv ----
// Self-checking bench of the timer status flags and registers.
`timescale 1ns/100ps
module tb_capture_compare_status_flags
   import ccs_pkg::*;
;
   localparam int PA = 0;
   localparam int PH = 1;
   localparam int PB = 2;
   localparam int PC = 3;
   localparam int PD = 4;
   localparam int PX = 5;
   logic core_clk_i;
   logic rst_b_i;
   logic low_power_i;
   ccs_axi_req_t req;
   ccs_axi_rsp_t rsp;
   logic [7:1] irq;
   logic [5:0] tgl;
   logic [5:0] lvl;
   logic [7:0] seed;
   logic [33:0] rq[$];
   int bad_count = 0;
   int total_checks = 0;
   ccs_timer dut_u (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .low_power_i(low_power_i),
      .axi_req_i(req), .axi_rsp_o(rsp), .cap_a_pin_i(lvl[0]), .head_switch_signal_i(lvl[1]),
      .cap_b_pin_i(lvl[2]), .cap_c_pin_i(lvl[3]), .cap_d_pin_i(lvl[4]),
      .ext_count_pulse_i(lvl[5]), .irq_o(irq));
   ccs_pin_model pin_u (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .tgl_i(tgl), .lvl_o(lvl));
   // ------------------------------
   // Tasks
   // ------------------------------
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   task automatic chk(input logic [33:0] s, input logic [33:0] e);
      total_checks++;
      if (s !== e) begin
         bad_count++;
         $display("ERROR at %0t: saw %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic hs(input int k);
      logic h;
      do begin
         @(negedge core_clk_i);
         h = (k == 0) ? rsp.arready : (k == 1) ? rsp.rvalid : rsp.bvalid;
         @(posedge core_clk_i);
      end while (!h);
   endtask : hs
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ap, wp, ah, wh;
      @(posedge core_clk_i);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hF;
      req.bready <= 1'b1;
      ap = 1'b1;
      wp = 1'b1;
      while (ap || wp) begin
         @(negedge core_clk_i);
         ah = ap && rsp.awready;
         wh = wp && rsp.wready;
         @(posedge core_clk_i);
         if (ah) req.awvalid <= 1'b0;
         if (wh) req.wvalid <= 1'b0;
         ap = ap && !ah;
         wp = wp && !wh;
      end
      hs(2);
      req.bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
      @(posedge core_clk_i);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      rq.push_back({r, d});
      hs(0);
      req.arvalid <= 1'b0;
      hs(1);
      req.rready <= 1'b0;
   endtask : rd
   task automatic ev(input int k);
      repeat (2) begin
         tgl <= 6'h01 << k;
         @(posedge core_clk_i);
         tgl <= 6'h00;
         repeat (8) @(posedge core_clk_i);
      end
   endtask : ev
   task automatic ci(input logic [7:1] e);
      @(negedge core_clk_i);
      chk({27'h0, irq}, {27'h0, e});
   endtask : ci
   task automatic tdone(input int n);
      $display("test %0d done", n);
   endtask : tdone
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : results
   // ------------------------------
   // Processes
   // ------------------------------
   initial begin
      core_clk_i = 1'b0;
      forever #4 core_clk_i = ~core_clk_i;
   end
   always @(negedge core_clk_i) begin
      if (rsp.rvalid && req.rready && rq.size() > 0) chk({rsp.rresp, rsp.rdata}, rq.pop_front());
      if (rsp.bvalid && req.bready) chk({32'h0, rsp.bresp}, {32'h0, RESP_OKAY});
   end
   initial begin
      repeat (20000) @(posedge core_clk_i);
      bad_count++;
      results();
   end
   initial begin
      req = '0;
      tgl = 6'h00;
      low_power_i = 1'b0;
      rst_b_i = 1'b0;
      seed = 8'h38;
      repeat (4) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      rd(OFS_STATUS, 32'h0);
      rd(OFS_IRQ_EN, 32'h0);
      rd(OFS_CMP_A, 32'hFFFF);
      rd(8'h40, 32'h0, RESP_SLVERR);
      seed = lfsr(seed);
      wr(OFS_STATUS, {24'h0, seed | 8'hFE});
      rd(OFS_STATUS, {31'h0, seed[0]});
      wr(OFS_STATUS, 32'h0);
      tdone(1);
      wr(OFS_CTRL, 32'hF3);
      wr(OFS_COUNT, 32'h1234);
      ev(PA);
      rd(OFS_CAP_A, 32'h1234);
      wr(OFS_STATUS, 32'h0);
      rd(OFS_STATUS, 32'h80);
      wr(OFS_STATUS, 32'h0);
      rd(OFS_STATUS, 32'h0);
      for (int k = PB; k <= PD; k++) begin
         wr(OFS_COUNT, 32'h2000 + k);
         ev(k);
         rd(8'(OFS_CAP_B + 4 * (k - PB)), 32'h2000 + k);
      end
      rd(OFS_STATUS, 32'h70);
      wr(OFS_STATUS, 32'h0);
      tdone(2);
      wr(OFS_IRQ_EN, 32'h01);
      wr(OFS_COUNT, 32'h3000);
      ev(PH);
      wr(OFS_COUNT, 32'h3001);
      ev(PA);
      rd(OFS_CAP_A, 32'h3000);
      wr(OFS_IRQ_EN, 32'h0);
      wr(OFS_CTRL, 32'hFF);
      wr(OFS_COUNT, 32'h4000);
      ev(PA);
      ev(PB);
      ev(PC);
      ev(PD);
      rd(OFS_CAP_C, 32'h3000);
      rd(OFS_CAP_D, 32'h2002);
      rd(OFS_CAP_B, 32'h4000);
      wr(OFS_IRQ_EN, 32'h30);
      ci(7'h18);
      rd(OFS_STATUS, 32'hF0);
      wr(OFS_STATUS, 32'h0);
      ci(7'h00);
      tdone(3);
      wr(OFS_CTRL, 32'hF3);
      wr(OFS_COUNT, 32'hFFFF);
      wr(OFS_IRQ_EN, 32'h02);
      ci(7'h00);
      ev(PX);
      rd(OFS_COUNT, 32'h0);
      ci(7'h01);
      wr(OFS_IRQ_EN, 32'h0);
      ci(7'h00);
      rd(OFS_STATUS, 32'h0E);
      wr(OFS_STATUS, 32'h0);
      wr(OFS_CMP_A, 32'h5);
      wr(OFS_CMP_B, 32'h6);
      wr(OFS_STATUS, 32'h1);
      wr(OFS_COUNT, 32'h5);
      ev(PX);
      rd(OFS_COUNT, 32'h0);
      rd(OFS_STATUS, 32'h09);
      wr(OFS_STATUS, 32'h0);
      wr(OFS_COUNT, 32'h6);
      ev(PX);
      rd(OFS_COUNT, 32'h7);
      rd(OFS_STATUS, 32'h04);
      tdone(4);
      @(posedge core_clk_i);
      low_power_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      low_power_i <= 1'b0;
      rd(OFS_STATUS, 32'h0);
      rd(OFS_CTRL, 32'h0);
      rd(OFS_CMP_B, 32'hFFFF);
      rd(OFS_CAP_B, 32'h0);
      wr(OFS_STATUS, 32'h0);
      // Low power left the divider at zero with divide-by-4 selected, so the count is known.
      rd(OFS_COUNT, 32'h4);
      tdone(5);
      results();
   end
endmodule : tb_capture_compare_status_flags
